// ==== common/sdpci_defines.svh ====
// constants of the sdram pin command interface: field positions, reset
// values and command codes. assumes inclusion by bare name only.
`ifndef SDPCI_DEFINES_SVH
`define SDPCI_DEFINES_SVH
// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define SDPCI_DQ_W 32
`define SDPCI_DQM_W 4
`define SDPCI_ADDR_W 14
`define SDPCI_BANK_W 2
`define SDPCI_NBANK 4
`define SDPCI_ROW_W 13
`define SDPCI_COL_W 10
`define SDPCI_DEPTH_W 8
// ----------------------------------------------------------------------
// field positions and timing
// ----------------------------------------------------------------------
`define SDPCI_AP_BIT 10
`define SDPCI_RD_MASK_LAT 2
`define SDPCI_BURST_LEN 8'h08
`define SDPCI_CAS_LAT 2
// ----------------------------------------------------------------------
// command codes {ras_n, cas_n, we_n}, conventional encoding
// ----------------------------------------------------------------------
`define SDPCI_CMD_NOP 3'h7
`define SDPCI_CMD_ACT 3'h3
`define SDPCI_CMD_RD 3'h5
`define SDPCI_CMD_WR 3'h4
`define SDPCI_CMD_BST 3'h6
`define SDPCI_CMD_PRE 3'h2
`define SDPCI_CMD_REF 3'h1
`define SDPCI_CMD_LMR 3'h0
`define SDPCI_MODE_RST 14'h0000
`endif

// ==== common/sdpci_pkg.sv ====
// types of the sdram pin command interface.
// assumes sdpci_defines.svh is on the include path.
`default_nettype none
`include "sdpci_defines.svh"
package sdpci_pkg;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [`SDPCI_BANK_W-1:0] bank;
        logic [`SDPCI_ADDR_W-1:0] addr;
    } sdpci_cmd_type;
    typedef enum logic [2:0] {
        SDPCI_OP_NONE,
        SDPCI_OP_ACT,
        SDPCI_OP_RD,
        SDPCI_OP_WR,
        SDPCI_OP_PRE,
        SDPCI_OP_REF,
        SDPCI_OP_LMR,
        SDPCI_OP_BST
    } sdpci_op_type;
    typedef enum {
        SDPCI_PWR_RUN,
        SDPCI_PWR_PRE_PD,
        SDPCI_PWR_ACT_PD,
        SDPCI_PWR_SELF_REF,
        SDPCI_PWR_DEEP_PD,
        SDPCI_PWR_SUSPEND
    } sdpci_pwr_type;
endpackage
`default_nettype wire

// ==== hw/sdpci_lane.sv ====
// one byte lane of the data path: write mask and read output pipeline.
// assumes the caller supplies one-cycle strobes in the core_clk domain.
`default_nettype none
module sdpci_lane (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic adv,
    input wire logic dqm,
    input wire logic wr_beat,
    input wire logic rd_beat,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [7:0] dq_o,
    output logic dq_oe
);
    logic [1:0] mask_d, mask_q;
    logic [7:0] dq_d, dq_q;
    logic oe_d, oe_q;

    // masked byte is not stored
    assign wr_en = wr_beat & ~dqm;

    always_comb begin
        mask_d = mask_q;
        dq_d = dq_q;
        oe_d = oe_q;
        if (adv) begin
            // read mask takes effect two clocks after sampling
            mask_d = {mask_q[0], dqm};
            dq_d = rd_data;
            oe_d = rd_beat & ~mask_q[1];
        end
    end

    // output register clocked by the system clock
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= 2'h0;
            dq_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
        end
    end

    assign dq_o = dq_q;
    assign dq_oe = oe_q;
endmodule
`default_nettype wire

// ==== hw/sdpci_top.sv ====
// command decode, power state and byte-masked data path of a four-bank
// sdram. assumes one clock; pins already synchronous to core_clk.
`default_nettype none
`include "sdpci_defines.svh"

module sdpci_top
    import sdpci_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cke,
    input wire sdpci_pkg::sdpci_cmd_type cmd,
    input wire logic [`SDPCI_DQM_W-1:0] dqm,
    input wire logic wide_mode,
    input wire logic dpd_req,
    input wire logic [`SDPCI_DQ_W-1:0] dq_i,
    input wire logic [`SDPCI_DQ_W-1:0] array_rd_data,
    output logic [`SDPCI_DQ_W-1:0] dq_o,
    output logic [`SDPCI_DQ_W-1:0] dq_oe,
    output logic [`SDPCI_DQM_W-1:0] array_wr_en,
    output logic [`SDPCI_DQ_W-1:0] array_wr_data,
    output logic [`SDPCI_BANK_W-1:0] array_bank,
    output logic [`SDPCI_ROW_W-1:0] array_row,
    output logic [`SDPCI_COL_W-1:0] array_col,
    output logic [`SDPCI_NBANK-1:0] bank_open,
    output logic [`SDPCI_ADDR_W-1:0] mode_reg,
    output logic in_buf_en,
    output logic [2:0] pwr_state
);
    import sdpci_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sdpci_pwr_type pwr_d, pwr_q;
    logic cke_q;
    logic [`SDPCI_NBANK-1:0] open_d, open_q, ap_d, ap_q;
    logic [`SDPCI_ROW_W-1:0] row_d [`SDPCI_NBANK];
    logic [`SDPCI_ROW_W-1:0] row_q [`SDPCI_NBANK];
    logic [`SDPCI_ADDR_W-1:0] mode_d, mode_q;
    logic [`SDPCI_BANK_W-1:0] bank_d, bank_q;
    logic [`SDPCI_COL_W-1:0] col_d, col_q;
    logic [`SDPCI_DEPTH_W-1:0] left_d, left_q;
    logic wr_act_d, wr_act_q, rd_act_d, rd_act_q;
    logic [`SDPCI_CAS_LAT-1:0] rd_pipe_d, rd_pipe_q;
    logic [`SDPCI_DQ_W-1:0] wdat_d, wdat_q;
    logic [`SDPCI_DQM_W-1:0] wen_d, wen_q;
    logic [`SDPCI_ROW_W-1:0] row_out_d, row_out_q;
    logic buf_en_d, buf_en_q;
    sdpci_op_type op;
    logic adv;
    logic [`SDPCI_DQM_W-1:0] lane_mask, lane_wen;
    logic [`SDPCI_DQ_W-1:0] lane_dq, lane_oe;
    logic wr_beat, rd_beat;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    always_comb begin
        op = SDPCI_OP_NONE;
        // decoder only enabled with chip select low
        if (!cmd.cs_n) begin
            // command from the unregistered strobe input levels
            case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
                `SDPCI_CMD_ACT: op = SDPCI_OP_ACT;
                `SDPCI_CMD_RD: op = SDPCI_OP_RD;
                `SDPCI_CMD_WR: op = SDPCI_OP_WR;
                `SDPCI_CMD_PRE: op = SDPCI_OP_PRE;
                `SDPCI_CMD_REF: op = SDPCI_OP_REF;
                `SDPCI_CMD_LMR: op = SDPCI_OP_LMR;
                `SDPCI_CMD_BST: op = SDPCI_OP_BST;
                default: op = SDPCI_OP_NONE;
            endcase
        end
    end

    // clock is live only while cke stays high and we are running
    assign adv = (pwr_q == SDPCI_PWR_RUN) && cke_q && cke;

    // ------------------------------------------------------------------
    // power state
    // ------------------------------------------------------------------
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            SDPCI_PWR_RUN: begin
                // state chosen by burst activity, bank condition, refresh command and dpd_req on cke falling
                if (cke_q && !cke) begin
                    if (rd_act_q || wr_act_q || (|rd_pipe_q))
                        pwr_d = SDPCI_PWR_SUSPEND;
                    else if (|open_q)
                        pwr_d = SDPCI_PWR_ACT_PD;
                    else if (op == SDPCI_OP_REF)
                        pwr_d = SDPCI_PWR_SELF_REF;
                    else if (dpd_req)
                        pwr_d = SDPCI_PWR_DEEP_PD;
                    else
                        pwr_d = SDPCI_PWR_PRE_PD;
                end
            end
            SDPCI_PWR_SUSPEND: begin
                if (cke)
                    pwr_d = SDPCI_PWR_RUN;
            end
            SDPCI_PWR_PRE_PD, SDPCI_PWR_ACT_PD, SDPCI_PWR_SELF_REF,
            SDPCI_PWR_DEEP_PD: begin
                // exit on cke level alone, no command needed
                if (cke)
                    pwr_d = SDPCI_PWR_RUN;
            end
            default: pwr_d = SDPCI_PWR_RUN;
        endcase
    end

    // ------------------------------------------------------------------
    // bank, address and burst logic
    // ------------------------------------------------------------------
    always_comb begin
        open_d = open_q;
        ap_d = ap_q;
        row_d = row_q;
        mode_d = mode_q;
        bank_d = bank_q;
        col_d = col_q;
        left_d = left_q;
        wr_act_d = wr_act_q;
        rd_act_d = rd_act_q;
        rd_pipe_d = rd_pipe_q;
        if (adv) begin
            // burst column counter advances on the clock
            if (left_q != 8'h00) begin
                left_d = left_q - 8'h01;
                col_d = col_q + 10'h001;
                if (left_q == 8'h01) begin
                    wr_act_d = 1'b0;
                    rd_act_d = 1'b0;
                    // auto precharge at end of access
                    if (ap_q[bank_q])
                        open_d[bank_q] = 1'b0;
                end
            end
            rd_pipe_d = {rd_pipe_q[`SDPCI_CAS_LAT-2:0], rd_act_q};
            case (op)
                SDPCI_OP_ACT: begin
                    // bank select and row sample
                    open_d[cmd.bank] = 1'b1;
                    row_d[cmd.bank] = cmd.addr[`SDPCI_ROW_W-1:0];
                end
                SDPCI_OP_RD, SDPCI_OP_WR: begin
                    // column sample; narrow mode uses a[9:0]
                    bank_d = cmd.bank;
                    col_d = wide_mode ? {1'b0, cmd.addr[8:0]}
                                      : cmd.addr[`SDPCI_COL_W-1:0];
                    ap_d[cmd.bank] = cmd.addr[`SDPCI_AP_BIT];
                    left_d = `SDPCI_BURST_LEN;
                    wr_act_d = (op == SDPCI_OP_WR);
                    rd_act_d = (op == SDPCI_OP_RD);
                end
                SDPCI_OP_PRE: begin
                    // bit 10 high: all banks, bank inputs ignored
                    if (cmd.addr[`SDPCI_AP_BIT])
                        open_d = '0;
                    else
                        open_d[cmd.bank] = 1'b0;
                end
                SDPCI_OP_LMR: mode_d = cmd.addr;
                SDPCI_OP_BST: begin
                    left_d = 8'h00;
                    wr_act_d = 1'b0;
                    rd_act_d = 1'b0;
                end
                default: ;
            endcase
        end
    end

    // inputs captured only on the rising edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_q <= SDPCI_PWR_RUN;
            cke_q <= 1'b1;
            open_q <= '0;
            ap_q <= '0;
            for (int i = 0; i < `SDPCI_NBANK; i++)
                row_q[i] <= '0;
            mode_q <= `SDPCI_MODE_RST;
            bank_q <= '0;
            col_q <= '0;
            left_q <= '0;
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            rd_pipe_q <= '0;
        end else begin
            pwr_q <= pwr_d;
            cke_q <= cke;
            open_q <= open_d;
            ap_q <= ap_d;
            row_q <= row_d;
            mode_q <= mode_d;
            bank_q <= bank_d;
            col_q <= col_d;
            left_q <= left_d;
            wr_act_q <= wr_act_d;
            rd_act_q <= rd_act_d;
            rd_pipe_q <= rd_pipe_d;
        end
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    always_comb begin
        wdat_d = dq_i;
        wen_d = lane_wen;
        // row of the addressed bank, registered so the pin is a flop
        row_out_d = row_d[bank_d];
        // buffers off outside run and suspend
        buf_en_d = (pwr_d == SDPCI_PWR_RUN) ||
                   (pwr_d == SDPCI_PWR_SUSPEND);
    end

    // write strobe lags its beat by one cycle; the array must allow for it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wdat_q <= '0;
            wen_q <= '0;
            row_out_q <= '0;
            buf_en_q <= 1'b1;
        end else begin
            wdat_q <= wdat_d;
            wen_q <= wen_d;
            row_out_q <= row_out_d;
            buf_en_q <= buf_en_d;
        end
    end

    // ------------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------------
    // narrow mode: upper mask bit 1 also covers unused upper pins
    assign lane_mask = wide_mode ? dqm : {dqm[1], dqm[1], dqm[1], dqm[0]};
    assign wr_beat = wr_act_d && adv;
    assign rd_beat = rd_pipe_q[`SDPCI_CAS_LAT-1];

    genvar g;
    generate
        for (g = 0; g < `SDPCI_DQM_W; g++) begin : g_lane
            // wide mode: mask bit g governs data byte g; narrow mode: bit 1 governs bytes 1 to 3
            // narrow mode: upper lanes never drive reads, pins stay released
            sdpci_lane u_lane (
                .core_clk(core_clk),
                .rstn(rstn),
                .adv(adv),
                .dqm(lane_mask[g]),
                .wr_beat(wr_beat),
                .rd_beat(rd_beat && (wide_mode || g < 2)),
                .wr_data(dq_i[8*g +: 8]),
                .rd_data(array_rd_data[8*g +: 8]),
                .wr_en(lane_wen[g]),
                .dq_o(lane_dq[8*g +: 8]),
                .dq_oe(lane_oe[8*g])
            );
            assign lane_oe[8*g+7 -: 7] = {7{lane_oe[8*g]}};
        end
    endgenerate

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign dq_o = lane_dq;
    assign dq_oe = lane_oe;
    assign array_wr_en = wen_q;
    assign array_wr_data = wdat_q;
    assign array_bank = bank_q;
    assign array_row = row_out_q;
    assign array_col = col_q;
    assign bank_open = open_q;
    assign mode_reg = mode_q;
    assign in_buf_en = buf_en_q;
    assign pwr_state = 3'(pwr_q);
endmodule
`default_nettype wire

// ==== bench/sdpci_top_sva.sv ====
// assertions on the ports of sdpci_top.
// assumes the bind below; single core_clk domain, rstn async low.
`default_nettype none
`include "sdpci_defines.svh"
module sdpci_top_sva
    import sdpci_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cke,
    input wire sdpci_pkg::sdpci_cmd_type cmd,
    input wire logic [3:0] dqm,
    input wire logic wide_mode,
    input wire logic [31:0] dq_oe,
    input wire logic [3:0] array_wr_en,
    input wire logic [3:0] bank_open,
    input wire logic [13:0] mode_reg,
    input wire logic in_buf_en,
    input wire logic [2:0] pwr_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cke_q;
    // clock-live history, oldest bit first
    logic [2:0] live_h;
    logic tk;
    logic pd;
    logic [2:0] op;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cke_q <= 1'b1;
            live_h <= 3'h0;
        end else begin
            cke_q <= cke;
            live_h <= {live_h[1:0], cke && cke_q && pwr_state == 3'h0};
        end
    end
    // a command counts only when the decoder really takes it
    assign tk = !cmd.cs_n && cke && cke_q && pwr_state == 3'h0;
    assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign pd = pwr_state inside {3'h1, 3'h2, 3'h3, 3'h4};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_act_opens: assert property (
        tk && op == `SDPCI_CMD_ACT |=> bank_open[$past(cmd.bank)])
        else $error("activate did not open the bank");
    a_cs_masks: assert property (
        cmd.cs_n |=> $stable(mode_reg))
        else $error("deselected command changed mode");
    a_cke_freeze: assert property (
        !cke |=> $stable(bank_open) && $stable(mode_reg))
        else $error("command taken with clock disabled");
    a_lmr_load: assert property (
        tk && op == `SDPCI_CMD_LMR |=> mode_reg == $past(cmd.addr))
        else $error("mode opcode not stored");
    a_pre_all: assert property (
        tk && op == `SDPCI_CMD_PRE && cmd.addr[10] |=> bank_open == 4'h0)
        else $error("all-bank precharge left a bank open");
    a_pre_one: assert property (
        tk && op == `SDPCI_CMD_PRE && !cmd.addr[10]
        |=> !bank_open[$past(cmd.bank)])
        else $error("single precharge left the bank open");
    a_wr_wide: assert property (
        wide_mode && array_wr_en[2] |-> !$past(dqm[2]))
        else $error("masked wide lane written");
    a_wr_narrow: assert property (
        !wide_mode && array_wr_en[3] |-> !$past(dqm[1]))
        else $error("masked upper lane written");
    a_rd_float: assert property (
        live_h == 3'h7 && $past(dqm[1], 3) |-> dq_oe[15:8] == 8'h00)
        else $error("masked read lane driven");
    a_pd_bufs: assert property (
        pd ##1 pd |-> !in_buf_en)
        else $error("input buffers on in power-down");
    c_act: cover property (tk && op == `SDPCI_CMD_ACT);
    c_lmr: cover property (tk && op == `SDPCI_CMD_LMR);
    c_float: cover property (dq_oe == 32'hffff00ff);
    c_suspend: cover property (pwr_state == 3'h5);
endmodule
bind sdpci_top sdpci_top_sva sdpci_top_sva_i (.core_clk(core_clk),
    .rstn(rstn), .cke(cke), .cmd(cmd), .dqm(dqm), .wide_mode(wide_mode),
    .dq_oe(dq_oe), .array_wr_en(array_wr_en), .bank_open(bank_open),
    .mode_reg(mode_reg), .in_buf_en(in_buf_en), .pwr_state(pwr_state));
`default_nettype wire

// ==== bench/sdpci_ctrl_model.sv ====
// controller side: turns an operation into command pin levels.
// assumes the bench changes its inputs on the falling edge.
`default_nettype none
`include "sdpci_defines.svh"
module sdpci_ctrl_model
    import sdpci_pkg::*;
(
    input wire sdpci_pkg::sdpci_op_type op,
    input wire logic sel,
    input wire logic [1:0] bank,
    input wire logic [13:0] addr,
    output var sdpci_pkg::sdpci_cmd_type cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] code;
    always_comb begin
        case (op)
            SDPCI_OP_ACT: code = `SDPCI_CMD_ACT;
            SDPCI_OP_RD: code = `SDPCI_CMD_RD;
            SDPCI_OP_WR: code = `SDPCI_CMD_WR;
            SDPCI_OP_PRE: code = `SDPCI_CMD_PRE;
            SDPCI_OP_REF: code = `SDPCI_CMD_REF;
            SDPCI_OP_LMR: code = `SDPCI_CMD_LMR;
            SDPCI_OP_BST: code = `SDPCI_CMD_BST;
            default: code = `SDPCI_CMD_NOP;
        endcase
        cmd = '{cs_n: !sel, ras_n: code[2], cas_n: code[1],
            we_n: code[0], bank: bank, addr: addr};
    end
endmodule
`default_nettype wire

// ==== bench/sdpci_top_tb.sv ====
// self-checking bench for sdpci_top through the controller model.
// assumes 100 MHz core_clk; inputs change on the falling edge.
`default_nettype none
`include "sdpci_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module sdpci_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sdpci_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cke = 1'b1, wide_mode = 1'b1, dpd_req = 1'b0, sel = 1'b0;
    logic [3:0] dqm = 4'h0, array_wr_en, bank_open;
    logic [31:0] dq_i = 32'h0, rd_data = 32'h0, dq_o, dq_oe, wr_data;
    logic [1:0] bank = 2'h0, array_bank;
    logic [13:0] addr = 14'h0, mode_reg;
    logic [12:0] array_row;
    logic [9:0] array_col;
    logic in_buf_en;
    logic [2:0] pwr_state;
    sdpci_op_type op = SDPCI_OP_NONE;
    sdpci_cmd_type cmd;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    sdpci_ctrl_model sdpci_ctrl_model_i (.op(op), .sel(sel), .bank(bank),
        .addr(addr), .cmd(cmd));
    sdpci_top sdpci_top_i (.core_clk(core_clk), .rstn(rstn), .cke(cke),
        .cmd(cmd), .dqm(dqm), .wide_mode(wide_mode), .dpd_req(dpd_req),
        .dq_i(dq_i), .array_rd_data(rd_data), .dq_o(dq_o), .dq_oe(dq_oe),
        .array_wr_en(array_wr_en), .array_wr_data(wr_data),
        .array_bank(array_bank), .array_row(array_row),
        .array_col(array_col), .bank_open(bank_open),
        .mode_reg(mode_reg), .in_buf_en(in_buf_en), .pwr_state(pwr_state));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic cyc_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // idle address lines show the inverse so a stale value cannot pass
    task automatic issue(input sdpci_op_type o, input logic s,
        input logic [1:0] b, input logic [13:0] a);
        @(negedge core_clk);
        op = o; sel = s; bank = b; addr = a;
        @(negedge core_clk);
        op = SDPCI_OP_NONE; sel = 1'b0; addr = ~a;
    endtask
    task automatic t_bank;
        issue(SDPCI_OP_ACT, 1'b0, 2'h1, 14'h0011);
        cyc_n(1);
        `CHK(bank_open, 4'h0)
        issue(SDPCI_OP_ACT, 1'b1, 2'h1, 14'h1abc);
        issue(SDPCI_OP_ACT, 1'b1, 2'h2, 14'h0abc);
        cyc_n(1);
        `CHK(bank_open, 4'h6)
        issue(SDPCI_OP_PRE, 1'b1, 2'h1, 14'h0000);
        cyc_n(1);
        `CHK(bank_open, 4'h4)
        issue(SDPCI_OP_PRE, 1'b1, 2'h1, 14'h0400);
        cyc_n(1);
        `CHK(bank_open, 4'h0)
        $display("test bank done");
    endtask
    task automatic t_lmr;
        issue(SDPCI_OP_LMR, 1'b1, 2'h0, 14'h0023);
        cyc_n(1);
        `CHK(mode_reg, 14'h0023)
        issue(SDPCI_OP_LMR, 1'b0, 2'h0, 14'h3fff);
        cyc_n(1);
        `CHK(mode_reg, 14'h0023)
        $display("test lmr done");
    endtask
    task automatic t_write(input logic wm, input logic [3:0] m,
        input logic [3:0] e);
        wide_mode = wm; dqm = m; dq_i = 32'hc3a5_5a3c;
        issue(SDPCI_OP_WR, 1'b1, 2'h0, 14'h0210);
        `CHK(array_col, wm ? 10'h010 : 10'h210)
        `CHK(array_wr_en, e)
        cyc_n(1);
        `CHK(array_wr_en, e)
        `CHK(wr_data, dq_i)
        cyc_n(9);
        `CHK(array_wr_en, 4'h0)
        dqm = 4'h0;
        $display("test write done");
    endtask
    // dqm is held through the burst so every beat floats the same lanes
    task automatic t_read(input logic [3:0] m, input logic [31:0] oe,
        input logic [13:0] a, input logic [3:0] open);
        dqm = m; rd_data = 32'h9876_5432;
        issue(SDPCI_OP_RD, 1'b1, 2'h1, a);
        `CHK(array_bank, 2'h1)
        `CHK(array_row, 13'h1abc)
        cyc_n(3);
        `CHK(dq_oe, oe)
        `CHK(dq_o & oe, rd_data & oe)
        cyc_n(9);
        `CHK(dq_oe, 32'h0)
        `CHK(bank_open, open)
        dqm = 4'h0;
        $display("test read done");
    endtask
    // clock suspend in mid write burst, then burst stop
    task automatic t_stop;
        dqm = 4'h0;
        issue(SDPCI_OP_WR, 1'b1, 2'h0, 14'h0020);
        cke = 1'b0;
        cyc_n(1);
        `CHK(pwr_state, 3'h5)
        `CHK(array_wr_en, 4'h0)
        `CHK(array_col, 10'h020)
        `CHK(in_buf_en, 1'b1)
        cke = 1'b1;
        cyc_n(2);
        `CHK(pwr_state, 3'h0)
        `CHK(array_col, 10'h021)
        `CHK(array_wr_en, 4'hf)
        issue(SDPCI_OP_BST, 1'b1, 2'h0, 14'h0000);
        `CHK(array_wr_en, 4'h0)
        $display("test stop done");
    endtask
    task automatic t_pd(input logic dp, input logic sr,
        input logic [2:0] st);
        @(negedge core_clk);
        dpd_req = dp; cke = 1'b0; sel = sr;
        if (sr) begin
            op = SDPCI_OP_REF;
        end
        @(negedge core_clk);
        op = SDPCI_OP_NONE; sel = 1'b0;
        cyc_n(3);
        `CHK(pwr_state, st)
        `CHK(in_buf_en, 1'b0)
        issue(SDPCI_OP_LMR, 1'b1, 2'h0, 14'h0001);
        `CHK(mode_reg, 14'h0023)
        cke = 1'b1; dpd_req = 1'b0;
        cyc_n(3);
        `CHK(pwr_state, 3'h0)
        `CHK(in_buf_en, 1'b1)
        $display("test power done");
    endtask
    task automatic wrap_up;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        t_bank();
        t_lmr();
        issue(SDPCI_OP_ACT, 1'b1, 2'h0, 14'h0123);
        issue(SDPCI_OP_ACT, 1'b1, 2'h1, 14'h1abc);
        t_write(1'b1, 4'h5, 4'ha);
        t_write(1'b0, 4'h2, 4'h1);
        wide_mode = 1'b1;
        t_read(4'h2, 32'hffff00ff, 14'h0005, 4'h3);
        t_read(4'h0, 32'hffffffff, 14'h0405, 4'h1);
        t_stop();
        t_pd(1'b0, 1'b0, 3'h2);
        issue(SDPCI_OP_PRE, 1'b1, 2'h3, 14'h0400);
        t_pd(1'b0, 1'b0, 3'h1);
        t_pd(1'b1, 1'b0, 3'h4);
        t_pd(1'b0, 1'b1, 3'h3);
        wrap_up();
    end
endmodule
`default_nettype wire
